// [rtl/usart_pkg.sv]
package usart_pkg;
  // serial word geometry and apb address width
  localparam int DATA_BITS = 8;
  localparam int ADDR_WIDTH = 12;

  // register indices; byte address is four times the index, bank one sits above BANK1_BASE
  localparam logic [7:0] IDX_RX_STATUS = 8'h13;
  localparam logic [7:0] IDX_RX_DATA = 8'h14;
  localparam logic [7:0] IDX_TX_STATUS = 8'h15;
  localparam logic [7:0] IDX_TX_DATA = 8'h16;
  localparam logic [7:0] IDX_BIT_RATE = 8'h17;
  localparam logic [7:0] IDX_FLAGS = 8'h16;
  localparam logic [7:0] IDX_ENABLES = 8'h17;
  localparam logic [11:0] BANK1_BASE = 12'h100;

  // receive_status_control fields
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_NINE_BIT_MODE = 6;
  localparam int RX_SINGLE_ENABLE = 5;
  localparam int RX_CONT_ENABLE = 4;
  localparam int RX_FRAMING_ERROR = 2;
  localparam int RX_OVERRUN_ERROR = 1;
  localparam int RX_NINTH_BIT = 0;

  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE = 7;
  localparam int TX_NINE_BIT_MODE = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC_SELECT = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH_BIT = 0;

  // flag and enable fields
  localparam int FLAG_TX_EMPTY = 1;
  localparam int FLAG_RX_FULL = 0;

  // reset values and the fixed interrupt vector
  localparam logic [7:0] RX_STATUS_RESET = 8'h00;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] BIT_RATE_RESET = 8'h00;
  localparam logic [15:0] INTERRUPT_VECTOR = 16'h0020;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_RX_STATUS, SEL_RX_DATA, SEL_TX_STATUS, SEL_TX_DATA, SEL_FLAGS, SEL_BIT_RATE, SEL_ENABLES
  } reg_sel_t;
endpackage

// [rtl/link_if.sv]
`timescale 1ns/1ps
interface link_if;
  logic ck_rise;
  logic ck_fall;
  logic dt;
  modport source (output ck_rise, output ck_fall, output dt);
  modport sink (input ck_rise, input ck_fall, input dt);
endinterface

// [rtl/link_sync.sv]
`timescale 1ns/1ps
module link_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic ck_pin,
  input wire logic dt_pin,
  // synchronised events
  link_if.source link
);
  typedef struct packed {
    logic ck_meta;
    logic ck_sync;
    logic ck_prev;
    logic dt_meta;
    logic dt_sync;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // only the second stage and later feed the edge detector
  always_comb begin
    next_st = st;
    next_st.ck_meta = ck_pin;
    next_st.ck_sync = st.ck_meta;
    next_st.ck_prev = st.ck_sync;
    next_st.dt_meta = dt_pin;
    next_st.dt_sync = st.dt_meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.ck_rise = st.ck_sync & ~st.ck_prev;
  assign link.ck_fall = ~st.ck_sync & st.ck_prev;
  assign link.dt = st.dt_sync;
endmodule

// [rtl/usart_sync_slave.sv]
`timescale 1ns/1ps
module usart_sync_slave (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usart_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // non power-on reset (external pin or watchdog), synchronous level
  input wire logic warm_reset,
  // transmit_clock_pin
  input wire logic ck_in,
  output logic ck_out,
  output logic ck_oe,
  // receive_data_pin
  input wire logic dt_in,
  output logic dt_out,
  output logic dt_oe,
  // toward the core
  output logic wake_request,
  output logic [15:0] interrupt_vector
);
  import usart_pkg::*;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

  typedef struct packed {
    logic [7:0] rx_ctrl;
    logic [7:0] tx_ctrl;
    logic [1:0] enables;
    logic [7:0] bit_rate;
    logic [7:0] tx_buf;
    logic tx_buf_full;
    tx_state_t tx_state;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_idx;
    logic dt_out;
    logic [8:0] receive_shift_register;
    logic [3:0] rx_cnt;
    logic overrun_error_flag;
    logic [1:0][8:0] fifo;
    logic rd_ptr;
    logic [1:0] fifo_cnt;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t st;
  state_t next_st;

  link_if link ();

  link_sync u_link_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ck_pin(ck_in),
    .dt_pin(dt_in),
    .link(link)
  );

  function automatic reg_sel_t decode(input logic [ADDR_WIDTH-1:0] a);
    case (a)
      {2'b00, IDX_RX_STATUS, 2'b00}: decode = SEL_RX_STATUS;
      {2'b00, IDX_RX_DATA, 2'b00}: decode = SEL_RX_DATA;
      {2'b00, IDX_TX_STATUS, 2'b00}: decode = SEL_TX_STATUS;
      {2'b00, IDX_TX_DATA, 2'b00}: decode = SEL_TX_DATA;
      {2'b00, IDX_BIT_RATE, 2'b00}: decode = SEL_BIT_RATE;
      BANK1_BASE | {2'b00, IDX_FLAGS, 2'b00}: decode = SEL_FLAGS;
      BANK1_BASE | {2'b00, IDX_ENABLES, 2'b00}: decode = SEL_ENABLES;
      default: decode = SEL_NONE;
    endcase
  endfunction

  logic port_on;
  logic slave_sel;
  logic tx_go;
  logic rx_en;
  logic transmit_buffer_empty_flag;
  logic receive_buffer_full_flag;
  logic tx_load;
  logic rx_done;
  logic push;
  logic pop;
  logic [3:0] last_tx;
  logic [3:0] last_rx;
  logic [8:0] shifted;
  logic [8:0] word;
  reg_sel_t sel;

  // slave mode: sync selected and clock source cleared
  assign port_on = st.rx_ctrl[RX_PORT_ENABLE];
  assign slave_sel = port_on & st.tx_ctrl[TX_SYNC_SELECT] & ~st.tx_ctrl[TX_CLOCK_SOURCE];
  // continuous receive overrides transmission; single receive plays no part
  assign tx_go = slave_sel & st.tx_ctrl[TX_ENABLE] & ~st.rx_ctrl[RX_CONT_ENABLE];
  assign rx_en = slave_sel & st.rx_ctrl[RX_CONT_ENABLE];
  assign transmit_buffer_empty_flag = ~st.tx_buf_full;
  assign receive_buffer_full_flag = st.fifo_cnt != 2'h0;
  assign last_tx = st.tx_ctrl[TX_NINE_BIT_MODE] ? 4'h8 : 4'h7;
  assign last_rx = st.rx_ctrl[RX_NINE_BIT_MODE] ? 4'h8 : 4'h7;
  assign sel = decode(paddr);

  always_comb begin
    next_st = st;
    tx_load = 1'b0;
    rx_done = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    shifted = {link.dt, st.receive_shift_register[8:1]};
    word = st.rx_ctrl[RX_NINE_BIT_MODE] ? shifted : {1'b0, shifted[8:1]};

    // transmitter; clearing enable or port aborts and resets it
    if (!st.tx_ctrl[TX_ENABLE] || !port_on) begin
      next_st.tx_state = TX_IDLE;
      next_st.dt_out = 1'b0;
    end else if (tx_go) begin
      case (st.tx_state)
        TX_IDLE: begin
          if (st.tx_buf_full) begin
            // ninth bit is taken as it stands right now
            next_st.transmit_shift_register = {st.tx_ctrl[TX_NINTH_BIT], st.tx_buf};
            next_st.tx_idx = 4'h0;
            next_st.dt_out = st.tx_buf[0];
            next_st.tx_buf_full = 1'b0;
            next_st.tx_state = TX_SHIFT;
            tx_load = 1'b1;
          end
        end
        TX_SHIFT: begin
          // master samples on the fall, so new data goes out on the rise
          if (link.ck_rise) begin
            next_st.dt_out = st.transmit_shift_register[st.tx_idx];
          end
          if (link.ck_fall) begin
            if (st.tx_idx == last_tx) begin
              next_st.tx_state = TX_IDLE;
            end else begin
              next_st.tx_idx = st.tx_idx + 4'h1;
            end
          end
        end
        default: next_st.tx_state = TX_IDLE;
      endcase
    end

    // receiver, lsb first, sampled on the falling shift clock edge
    if (!rx_en) begin
      next_st.rx_cnt = 4'h0;
      next_st.receive_shift_register = 9'h000;
    end else if (link.ck_fall) begin
      next_st.receive_shift_register = shifted;
      if (st.rx_cnt == last_rx) begin
        next_st.rx_cnt = 4'h0;
        rx_done = 1'b1;
      end else begin
        next_st.rx_cnt = st.rx_cnt + 4'h1;
      end
    end

    // a word completing into a full fifo is dropped and locks out transfers
    if (rx_done && !st.overrun_error_flag) begin
      if (st.fifo_cnt == 2'h2) begin
        next_st.overrun_error_flag = 1'b1;
      end else begin
        next_st.fifo[st.rd_ptr ^ st.fifo_cnt[0]] = word;
        push = 1'b1;
      end
    end
    if (!st.rx_ctrl[RX_CONT_ENABLE]) begin
      next_st.overrun_error_flag = 1'b0;
    end

    // apb read data is captured in the setup phase
    if (psel && !penable) begin
      next_st.pslverr = 1'b0;
      case (sel)
        SEL_RX_STATUS: next_st.prdata = {24'h000000, st.rx_ctrl[7:4], 1'b0, 1'b0, st.overrun_error_flag, st.fifo[st.rd_ptr][8]};
        SEL_RX_DATA: next_st.prdata = {24'h000000, st.fifo[st.rd_ptr][7:0]};
        SEL_TX_STATUS: next_st.prdata = {24'h000000, st.tx_ctrl[7:4], 2'b00, st.tx_state == TX_IDLE,
                                         st.tx_ctrl[TX_NINTH_BIT]};
        SEL_BIT_RATE: next_st.prdata = {24'h000000, st.bit_rate};
        SEL_FLAGS: next_st.prdata = {30'h00000000, transmit_buffer_empty_flag, receive_buffer_full_flag};
        SEL_ENABLES: next_st.prdata = {30'h00000000, st.enables};
        SEL_TX_DATA: next_st.prdata = 32'h00000000;
        default: begin
          next_st.prdata = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end

    // register effects land at the access edge
    if (psel && penable) begin
      if (pwrite) begin
        case (sel)
          SEL_RX_STATUS: next_st.rx_ctrl[7:4] = pwdata[7:4];
          SEL_TX_STATUS: begin
            next_st.tx_ctrl[7:4] = pwdata[7:4];
            next_st.tx_ctrl[TX_NINTH_BIT] = pwdata[TX_NINTH_BIT];
          end
          SEL_TX_DATA: begin
            // a write overlapping a load keeps the new word buffered
            next_st.tx_buf = pwdata[7:0];
            next_st.tx_buf_full = 1'b1;
          end
          SEL_BIT_RATE: next_st.bit_rate = pwdata[7:0];
          SEL_ENABLES: next_st.enables = pwdata[1:0];
          default: next_st.enables = st.enables;
        endcase
      end else if (sel == SEL_RX_DATA && receive_buffer_full_flag) begin
        pop = 1'b1;
        next_st.rd_ptr = ~st.rd_ptr;
      end
    end
    next_st.fifo_cnt = 2'(st.fifo_cnt + {1'b0, push} - {1'b0, pop});

    // warm reset: control to zero, received data and ninth bit kept
    if (warm_reset) begin
      next_st.rx_ctrl = RX_STATUS_RESET;
      next_st.tx_ctrl = TX_STATUS_RESET & 8'hF1;
      next_st.enables = ENABLES_RESET[1:0];
      next_st.tx_state = TX_IDLE;
      next_st.tx_buf_full = 1'b0;
      next_st.dt_out = 1'b0;
      next_st.rx_cnt = 4'h0;
      next_st.overrun_error_flag = 1'b0;
      next_st.fifo_cnt = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.rx_ctrl <= RX_STATUS_RESET;
      st.tx_ctrl <= TX_STATUS_RESET & 8'hF1;
      st.enables <= ENABLES_RESET[1:0];
      st.bit_rate <= BIT_RATE_RESET;
      st.tx_state <= TX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // apb answers with no wait state
  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;

  // the clock pin is never driven; the master owns it
  assign ck_out = 1'b0;
  assign ck_oe = 1'b0;
  assign dt_out = st.dt_out;
  assign dt_oe = tx_go;

  // wake does not depend on any core clock gating, so it works in sleep
  assign wake_request = (transmit_buffer_empty_flag & st.enables[FLAG_TX_EMPTY]) | (receive_buffer_full_flag & st.enables[FLAG_RX_FULL]);
  assign interrupt_vector = INTERRUPT_VECTOR;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_slave_no_drive_in_master;
    st.tx_ctrl[TX_CLOCK_SOURCE] |-> !dt_oe && !ck_oe;
  endproperty
  a_slave_no_drive_in_master: assert property (p_slave_no_drive_in_master) else $error("drive with clock source set");

  property p_load_after_write;
    (psel && penable && pwrite && sel == SEL_TX_DATA && tx_go && st.tx_state == TX_IDLE && !warm_reset)
      |=> ##[0:1] (st.tx_state == TX_SHIFT);
  endproperty
  a_load_after_write: assert property (p_load_after_write) else $error("buffered word not loaded");

  property p_flag_clear_while_busy;
    (st.tx_buf_full && st.tx_state == TX_SHIFT) |-> !wake_request || !st.enables[FLAG_TX_EMPTY] || receive_buffer_full_flag;
  endproperty
  a_flag_clear_while_busy: assert property (p_flag_clear_while_busy) else $error("empty flag wakes while full");

  property p_reload_then_flag;
    (st.tx_state == TX_SHIFT && next_st.tx_state == TX_IDLE && st.tx_buf_full && tx_go && !warm_reset)
      |=> ##1 (st.tx_state == TX_SHIFT && transmit_buffer_empty_flag);
  endproperty
  a_reload_then_flag: assert property (p_reload_then_flag) else $error("second word not reloaded");

  property p_dt_changes_on_rise;
    (tx_go && $past(tx_go) && $changed(st.dt_out)) |-> $past(link.ck_rise || tx_load);
  endproperty
  a_dt_changes_on_rise: assert property (p_dt_changes_on_rise) else $error("data changed off rising edge");

  property p_rx_reset_when_off;
    !rx_en |=> st.rx_cnt == 4'h0 && st.receive_shift_register == 9'h000;
  endproperty
  a_rx_reset_when_off: assert property (p_rx_reset_when_off) else $error("receiver not reset");

  property p_error_cleared;
    (st.overrun_error_flag && !st.rx_ctrl[RX_CONT_ENABLE]) |=> !st.overrun_error_flag;
  endproperty
  a_error_cleared: assert property (p_error_cleared) else $error("overrun kept after enable cleared");

  property p_overrun_on_full;
    (rx_done && st.fifo_cnt == 2'h2 && !warm_reset) |=> st.overrun_error_flag && st.fifo == $past(st.fifo);
  endproperty
  a_overrun_on_full: assert property (p_overrun_on_full) else $error("overrun not flagged");

  property p_push_counts;
    (rx_done && !st.overrun_error_flag && st.fifo_cnt == 2'h0 && !pop && !warm_reset) |=> st.fifo_cnt == 2'h1 && receive_buffer_full_flag;
  endproperty
  a_push_counts: assert property (p_push_counts) else $error("word not moved to fifo");

  property p_pop_advances;
    (pop && !push && !warm_reset) |=> st.fifo_cnt == $past(st.fifo_cnt) - 2'h1 && st.rd_ptr != $past(st.rd_ptr);
  endproperty
  a_pop_advances: assert property (p_pop_advances) else $error("read did not advance fifo");

  property p_warm_keeps_data;
    warm_reset |=> st.rx_ctrl == 8'h00 && st.fifo == $past(st.fifo) && st.rd_ptr == $past(st.rd_ptr);
  endproperty
  a_warm_keeps_data: assert property (p_warm_keeps_data) else $error("warm reset lost data");

  c_tx_load: cover property (tx_load);
  c_rx_push: cover property (push);
  c_overrun: cover property (rx_done && st.fifo_cnt == 2'h2);
  c_back_to_back: cover property (tx_load ##[1:400] tx_load);
endmodule

// [sim/sync_master_model.sv]
`timescale 1ns/1ps
module sync_master_model (
  // shift clock toward the device pin
  output logic ck,
  // data the master puts on the shared line
  output logic dt_drive,
  // resolved shared data line
  input wire logic dt_line
);
  initial begin
    ck = 1'b0;
    dt_drive = 1'b0;
  end

  // one frame of n bits, lsb first; clock stands low outside frames
  task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = '0;
    #7;
    for (int i = 0; i < n; i++) begin
      dt_drive = tx[i];
      #5 ck = 1'b1;
      #40 ck = 1'b0;
      rx[i] = dt_line;
      // hold well past the device's synchronised falling edge
      #35;
    end
    // released line shows the inverse, not a stale copy
    dt_drive = ~dt_drive;
  endtask
endmodule

// [sim/usart_sync_slave_tb_top.sv]
`timescale 1ns/1ps
module usart_sync_slave_tb_top;
  import usart_pkg::*;
  localparam logic [11:0] A_RXS = {2'b00, IDX_RX_STATUS, 2'b00};
  localparam logic [11:0] A_RXD = {2'b00, IDX_RX_DATA, 2'b00};
  localparam logic [11:0] A_TXS = {2'b00, IDX_TX_STATUS, 2'b00};
  localparam logic [11:0] A_TXD = {2'b00, IDX_TX_DATA, 2'b00};
  localparam logic [11:0] A_BRG = {2'b00, IDX_BIT_RATE, 2'b00};
  localparam logic [11:0] A_FLG = BANK1_BASE + {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_ENA = BANK1_BASE + {2'b00, IDX_ENABLES, 2'b00};
  localparam logic [11:0] A_BAD = 12'h0A0;
  logic pclk, presetn, psel, penable, pwrite, warm_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ck_line, ck_out, ck_oe, dt_out, dt_oe, m_dt, dt_line, wake_request, err, nb;
  logic [15:0] interrupt_vector;
  logic [8:0] w1, w2, got;
  logic [8:0] rw [4];
  logic [7:0] brg;
  logic [31:0] seed = 32'h0000003F;
  int num_errors = 0;
  int comparisons = 0;

  // shared data wire: device drives when enabled, otherwise the master
  assign dt_line = dt_oe ? dt_out : m_dt;

  usart_sync_slave usart_sync_slave_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .warm_reset(warm_reset), .ck_in(ck_line), .ck_out(ck_out), .ck_oe(ck_oe),
    .dt_in(dt_line), .dt_out(dt_out), .dt_oe(dt_oe),
    .wake_request(wake_request), .interrupt_vector(interrupt_vector)
  );
  sync_master_model sync_master_model_inst (.ck(ck_line), .dt_drive(m_dt), .dt_line(dt_line));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // framing error always reads zero in synchronous mode
  function automatic logic [31:0] rxs_exp(input logic [7:0] ctl, input logic ovr, input logic ninth);
    return {24'h0, ctl[7:4], 2'b00, ovr, ninth};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // no fixed latency assumed: wait for pready under a bound
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00, rd, err);
    chk(rd, e);
  endtask

  // synchroniser plus push latency
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    warm_reset = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_RXS, 32'h00);
    rdchk(A_TXS, 32'h02);
    rdchk(A_FLG, 32'h02);
    rdchk(A_ENA, 32'h00);
    xfer(1'b0, A_BAD, 8'hFF, rd, err);
    chk({rd[30:0], err}, 32'h1);
    // transmit: first word before enable, second while shifter busy
    rd = xs();
    w1 = rd[8:0];
    rd = xs();
    w2 = {w1[8], rd[7:0]};
    nb = w1[8];
    wr(A_ENA, 8'h02);
    wr(A_RXS, 8'h80);
    wr(A_TXS, {7'b0101000, nb});
    wr(A_TXD, w1[7:0]);
    wr(A_TXS, {7'b0111000, nb});
    wr(A_TXD, w2[7:0]);
    rdchk(A_FLG, 32'h00);
    chk({31'h0, dt_oe}, 32'h1);
    chk({30'h0, ck_out, ck_oe}, 32'h0);
    sync_master_model_inst.frame(9, 9'h1AA, got);
    chk({23'h0, got}, {23'h0, w1});
    settle();
    rdchk(A_FLG, 32'h02);
    chk({31'h0, wake_request}, 32'h1);
    chk({16'h0000, interrupt_vector}, 32'h0020);
    sync_master_model_inst.frame(9, 9'h055, got);
    chk({23'h0, got}, {23'h0, w2});
    settle();
    rdchk(A_TXS, {24'h0, 7'b0111001, nb});
    // eight-bit word written with the shifter idle and enable already set
    wr(A_TXS, 8'h30);
    wr(A_TXD, w1[7:0]);
    sync_master_model_inst.frame(8, 9'h0F0, got);
    chk({23'h0, got}, {24'h0, w1[7:0]});
    // receive three words into a two-deep fifo, single enable set too
    wr(A_TXS, 8'h10);
    wr(A_ENA, 8'h01);
    wr(A_RXS, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      rd = xs();
      rw[i] = rd[8:0];
    end
    for (int i = 0; i < 3; i++) begin
      sync_master_model_inst.frame(9, rw[i], got);
      settle();
      if (i == 0) begin
        rdchk(A_FLG, 32'h03);
        chk({31'h0, wake_request}, 32'h1);
      end
    end
    rdchk(A_RXS, rxs_exp(8'hF0, 1'b1, rw[0][8]));
    rdchk(A_RXD, {23'h0, rw[0]} & 32'hFF);
    rdchk(A_RXS, rxs_exp(8'hF0, 1'b1, rw[1][8]));
    rdchk(A_RXD, {23'h0, rw[1]} & 32'hFF);
    rdchk(A_FLG, 32'h02);
    wr(A_RXS, 8'hC0);
    xfer(1'b0, A_RXS, 8'h00, rd, err);
    chk(rd & 32'hFE, 32'hC0);
    wr(A_RXS, 8'hD0);
    sync_master_model_inst.frame(9, rw[3], got);
    settle();
    rdchk(A_RXS, rxs_exp(8'hD0, 1'b0, rw[3][8]));
    // warm reset keeps data and divisor, zeroes control
    rd = xs();
    brg = rd[7:0];
    wr(A_BRG, brg);
    @(posedge pclk);
    warm_reset <= 1'b1;
    @(posedge pclk);
    warm_reset <= 1'b0;
    rdchk(A_RXS, {31'h0, rw[3][8]});
    rdchk(A_RXD, {23'h0, rw[3]} & 32'hFF);
    rdchk(A_TXS, 32'h02);
    rdchk(A_BRG, {24'h0, brg});
    rdchk(A_ENA, 32'h00);
    chk({31'h0, wake_request}, 32'h0);
    end_of_test();
  end
endmodule
